// >>> design/board_strap_config_decoder.sv
// Top of the board strap and switch configuration decoder with its Avalon-MM register slave.
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module board_strap_config_decoder
	import strap_cfg_pkg::*;
#(
	parameter int RTC_50_DIV = RTC_50_CYC,
	parameter int RTC_60_DIV = RTC_60_CYC
)(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire strap_in_t   straps,
	input  wire logic        console_break,
	input  wire logic        dma_req_tx,
	input  wire logic        dma_req_rx,
	input  wire logic        dma_req_timer,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output boot_cfg_t        boot_cfg,
	output logic             bus_enable,
	output logic [21:0]      slave_base,
	output logic             rtc_tick,
	output logic             break_trap,
	output logic             baud_from_straps,
	output logic [15:0]      baud_rate,
	output logic [1:0]       xfer_req,
	output logic             irq
);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	localparam int SYNC_W = $bits(strap_in_t) + 4;

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {straps, console_break, dma_req_tx, dma_req_rx, dma_req_timer};
			sync2_r <= sync1_r;
		end
	end

	strap_in_t st;
	logic      brk_s;
	logic      req_tx_s;
	logic      req_rx_s;
	logic      req_tm_s;

	assign {st, brk_s, req_tx_s, req_rx_s, req_tm_s} = sync2_r;

	// ------------------------------------------------------------------
	// Boot option decode
	// ------------------------------------------------------------------
	boot_cfg_t boot_dec;

	boot_option_decode u_boot (
		.boot_sel (st.boot_sel),
		.cfg      (boot_dec)
	);

	// ------------------------------------------------------------------
	// Base address and baud decode
	// ------------------------------------------------------------------
	function automatic logic [21:0] base_of(input logic [3:0] id, input logic hi);
		logic [21:0] start;
		logic [3:0]  first;
		logic [3:0]  idx;
		start = '0;
		first = '0;
		idx   = '0;
		if (id < ID_FIRST_B) begin
			start = hi ? BASE_HI_A : BASE_LO_A;
			first = ID_FIRST_A;
		end else begin
			start = hi ? BASE_HI_B : BASE_LO_B;
			first = ID_FIRST_B;
		end
		idx = id - first;
		base_of = start + BASE_STEP * {18'h0, idx};
	endfunction : base_of

	function automatic logic [15:0] baud_of(input logic [2:0] code);
		logic [31:0] rate;
		rate = BAUD_MAX >> code;
		baud_of = rate[15:0];
	endfunction : baud_of

	logic [2:0] hw_code;
	logic [2:0] swbaud_r;
	logic [2:0] swbaud_nxt;

	// A strap that is out reads as one; the three straps form a binary code, and each step of that code halves the rate.
	assign hw_code = {st.baud_code_strap_msb, st.baud_code_strap_mid, st.baud_code_strap_lsb};

	// ------------------------------------------------------------------
	// Real-time clock divider
	// ------------------------------------------------------------------
	logic [31:0] rtc_cnt_r;
	logic [31:0] rtc_cnt_nxt;
	logic        rtc_ev;
	logic [31:0] rtc_div;

	// Strap low selects the 60 Hz setting that is shipped as default.
	assign rtc_div = st.clock_rate_strap ? 32'(RTC_50_DIV) : 32'(RTC_60_DIV);
	assign rtc_ev  = (rtc_cnt_r >= rtc_div - 32'h1);

	always_comb begin
		rtc_cnt_nxt = rtc_ev ? 32'h0 : rtc_cnt_r + 32'h1;
	end

	// ------------------------------------------------------------------
	// Break edge detection
	// ------------------------------------------------------------------
	logic brk_d_r;
	logic brk_ev;

	assign brk_ev = brk_s & ~brk_d_r & st.break_trap_strap;

	// ------------------------------------------------------------------
	// DMA request routing
	// ------------------------------------------------------------------
	dma_sel_t dsel;
	logic     dma_bad;
	logic [1:0] xreq_nxt;

	assign dsel    = st.dma_route_strap;
	assign dma_bad = dsel.tx_sel & dsel.timer_sel & dsel.rx_sel;

	always_comb begin
		xreq_nxt = 2'h0;
		if (!dma_bad) begin
			// Channel 0 takes transmit, otherwise the timer; channel 1 takes receive, otherwise the timer.
			xreq_nxt[0] = dsel.tx_sel ? req_tx_s : (dsel.timer_sel & ~dsel.rx_sel & req_tm_s);
			xreq_nxt[1] = dsel.rx_sel ? req_rx_s : (dsel.timer_sel & ~dsel.tx_sel & req_tm_s);
			if (dsel.tx_sel & dsel.timer_sel & ~dsel.rx_sel) begin
				xreq_nxt[1] = req_tm_s;
			end
			if (dsel.rx_sel & dsel.timer_sel & ~dsel.tx_sel) begin
				xreq_nxt[0] = req_tm_s;
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------------
	logic [IRQ_W-1:0] status_r;
	logic [IRQ_W-1:0] status_nxt;
	logic [IRQ_W-1:0] mask_r;
	logic [IRQ_W-1:0] mask_nxt;
	logic [IRQ_W-1:0] ev_set;
	logic             wr_ok;
	logic             rd_ok;

	// A write lands at the edge at which the master sees waitrequest low, together with its release.
	assign wr_ok = avs_write & ~avs_waitrequest;
	assign rd_ok = avs_read & avs_waitrequest;

	always_comb begin
		ev_set = '0;
		ev_set[IRQ_RTC_BIT]     = rtc_ev;
		ev_set[IRQ_BREAK_BIT]   = brk_ev;
		ev_set[IRQ_BADBOOT_BIT] = ~boot_dec.valid;
		ev_set[IRQ_BADDMA_BIT]  = dma_bad;
		status_nxt = status_r;
		mask_nxt   = mask_r;
		swbaud_nxt = swbaud_r;
		if (wr_ok && avs_byteenable[0]) begin
			if (avs_address == 5'(REG_STATUS_OFS)) begin
				status_nxt = status_r & ~avs_writedata[IRQ_W-1:0];
			end
			if (avs_address == REG_MASK_OFS) begin
				mask_nxt = avs_writedata[IRQ_W-1:0];
			end
			if (avs_address == REG_SWBAUD_OFS) begin
				swbaud_nxt = avs_writedata[2:0];
			end
		end
		status_nxt = status_nxt | ev_set;
	end

	// ------------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------------
	logic [31:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 32'h0;
		case (avs_address)
			5'(REG_BOOT_OFS):   rdata_nxt = {18'h0, st.boot_sel, boot_dec};
			5'(REG_ADDR_OFS):   rdata_nxt = {5'h0, bus_enable, st.id_sel, slave_base};
			5'(REG_MISC_OFS):   rdata_nxt = {9'h0, dma_bad, st.clock_rate_strap, st.break_trap_strap,
				baud_from_straps, hw_code, baud_rate};
			5'(REG_STATUS_OFS): rdata_nxt = {28'h0, status_r};
			REG_MASK_OFS:       rdata_nxt = {28'h0, mask_r};
			REG_SWBAUD_OFS:     rdata_nxt = {29'h0, swbaud_r};
			REG_EVENT_OFS:      rdata_nxt = {30'h0, xfer_req};
			default:            rdata_nxt = 32'h0;
		endcase
	end

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	logic        bus_en_nxt;
	logic [21:0] base_nxt;
	logic        hwb_nxt;
	logic [15:0] baud_nxt;

	always_comb begin
		bus_en_nxt = (st.id_sel >= ID_FIRST_A);
		base_nxt   = bus_en_nxt ? base_of(st.id_sel, st.address_range_strap) : 22'h0;
		hwb_nxt    = st.baud_source_strap;
		baud_nxt   = baud_of(hwb_nxt ? hw_code : swbaud_r);
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rtc_cnt_r        <= 32'h0;
			brk_d_r          <= 1'b0;
			status_r         <= '0;
			mask_r           <= MASK_RST;
			swbaud_r         <= SWBAUD_RST;
			avs_readdata     <= 32'h0;
			avs_waitrequest  <= 1'b1;
			boot_cfg         <= '0;
			bus_enable       <= 1'b0;
			slave_base       <= 22'h0;
			rtc_tick         <= 1'b0;
			break_trap       <= 1'b0;
			baud_from_straps <= 1'b0;
			baud_rate        <= 16'h0;
			xfer_req         <= 2'h0;
			irq              <= 1'b0;
		end else begin
			rtc_cnt_r        <= rtc_cnt_nxt;
			brk_d_r          <= brk_s;
			status_r         <= status_nxt;
			mask_r           <= mask_nxt;
			swbaud_r         <= swbaud_nxt;
			if (rd_ok) begin
				avs_readdata <= rdata_nxt;
			end
			// Each access is answered one cycle after it is presented.
			avs_waitrequest  <= ~((avs_read | avs_write) & avs_waitrequest);
			boot_cfg         <= boot_dec;
			bus_enable       <= bus_en_nxt;
			slave_base       <= base_nxt;
			rtc_tick         <= rtc_ev;
			break_trap       <= brk_ev;
			baud_from_straps <= hwb_nxt;
			baud_rate        <= baud_nxt;
			xfer_req         <= xreq_nxt;
			irq              <= |(status_nxt & mask_nxt);
		end
	end

endmodule : board_strap_config_decoder
`default_nettype wire

// >>> design/strap_cfg_pkg.sv
// Package with constants, field layouts and types for the strap configuration decoder.
package strap_cfg_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0]  REG_BOOT_OFS    = 4'h0;
	localparam logic [3:0]  REG_ADDR_OFS    = 4'h4;
	localparam logic [3:0]  REG_MISC_OFS    = 4'h8;
	localparam logic [3:0]  REG_STATUS_OFS  = 4'hC;
	localparam logic [4:0]  REG_MASK_OFS    = 5'h10;
	localparam logic [4:0]  REG_SWBAUD_OFS  = 5'h14;
	localparam logic [4:0]  REG_EVENT_OFS   = 5'h18;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  SWBAUD_RST      = 3'h2;
	localparam logic [3:0]  MASK_RST        = 4'h0;

	// ----------------------------------------------------------------
	// Status and mask bit positions
	// ----------------------------------------------------------------
	localparam int          IRQ_RTC_BIT     = 0;
	localparam int          IRQ_BREAK_BIT   = 1;
	localparam int          IRQ_BADBOOT_BIT = 2;
	localparam int          IRQ_BADDMA_BIT  = 3;
	localparam int          IRQ_W           = 4;

	// ----------------------------------------------------------------
	// Base addresses (22-bit, octal as printed)
	// ----------------------------------------------------------------
	localparam logic [21:0] BASE_LO_A       = 22'o17760100;
	localparam logic [21:0] BASE_LO_B       = 22'o17775400;
	localparam logic [21:0] BASE_HI_A       = 22'o17762100;
	localparam logic [21:0] BASE_HI_B       = 22'o17777400;
	localparam logic [21:0] BASE_STEP       = 22'o40;
	localparam logic [3:0]  ID_FIRST_A      = 4'h2;
	localparam logic [3:0]  ID_FIRST_B      = 4'h8;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_HZ          = 200_000_000;
	localparam int          RTC_50_HZ       = 50;
	localparam int          RTC_60_HZ       = 60;
	localparam int          RTC_50_CYC      = CLK_HZ / RTC_50_HZ;
	localparam int          RTC_60_CYC      = CLK_HZ / RTC_60_HZ;
	localparam int          BAUD_MAX        = 38400;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RUN_USER_ROM   = 2'h0,
		RUN_TAPE_LOAD  = 2'h1,
		RUN_WAIT_CMD   = 2'h2,
		RUN_NONE       = 2'h3
	} run_mode_t;

	typedef struct packed {
		logic       valid;
		logic       self_test;
		logic       rom_test;
		logic       loopback_test;
		logic       ram_low;
		logic       debug_monitor;
		logic       diag_wait;
		run_mode_t  run_mode;
	} boot_cfg_t;

	typedef struct packed {
		logic [3:0] boot_sel;
		logic [3:0] id_sel;
		logic       address_range_strap;
		logic       clock_rate_strap;
		logic       break_trap_strap;
		logic       baud_source_strap;
		logic       baud_code_strap_msb;
		logic       baud_code_strap_mid;
		logic       baud_code_strap_lsb;
		logic [2:0] dma_route_strap;
	} strap_in_t;

	typedef struct packed {
		logic       tx_sel;
		logic       rx_sel;
		logic       timer_sel;
	} dma_sel_t;

endpackage : strap_cfg_pkg

// >>> design/boot_option_decode.sv
// Boot and self-test option decoder for the 16-position boot selector.
`timescale 1ns/1ps
`default_nettype none

module boot_option_decode
	import strap_cfg_pkg::*;
(
	input  wire logic [3:0] boot_sel,
	output var  boot_cfg_t  cfg
);

	always_comb begin
		cfg = '0;
		cfg.run_mode = RUN_NONE;
		cfg.valid = 1'b1;
		case (boot_sel)
			4'h0: begin
				cfg.run_mode = RUN_USER_ROM;
			end
			4'h1: begin
				cfg.run_mode  = RUN_USER_ROM;
				cfg.self_test = 1'b1;
			end
			4'h2: begin
				cfg.run_mode  = RUN_USER_ROM;
				cfg.self_test = 1'b1;
				cfg.rom_test  = 1'b1;
			end
			4'h3: begin
				cfg.run_mode  = RUN_TAPE_LOAD;
				cfg.self_test = 1'b1;
			end
			4'h4: begin
				cfg.debug_monitor = 1'b1;
			end
			4'h5: begin
				cfg.run_mode  = RUN_WAIT_CMD;
				cfg.self_test = 1'b1;
			end
			4'h6: begin
				cfg.run_mode = RUN_WAIT_CMD;
			end
			4'h8, 4'h9: begin
				cfg.self_test     = 1'b1;
				cfg.loopback_test = 1'b1;
				cfg.ram_low       = 1'b1;
				cfg.rom_test      = (boot_sel == 4'h9);
			end
			4'hA: begin
				cfg.self_test = 1'b1;
				cfg.ram_low   = 1'b1;
				cfg.diag_wait = 1'b1;
			end
			default: begin
				cfg.valid = 1'b0;
			end
		endcase
	end

endmodule : boot_option_decode
`default_nettype wire

// >>> bench/board_strap_config_decoder_properties.sv
// Checker of the strap decoder outputs against the strap and request levels.
`timescale 1ns/1ps
`default_nettype none
module strap_cfg_checker
	import strap_cfg_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire strap_in_t   straps,
	input wire logic        dma_req_tx,
	input wire logic        dma_req_rx,
	input wire logic        dma_req_timer,
	input wire boot_cfg_t   boot_cfg,
	input wire logic        bus_enable,
	input wire logic [21:0] slave_base,
	input wire logic        rtc_tick,
	input wire logic        break_trap,
	input wire logic        baud_from_straps,
	input wire logic [15:0] baud_rate,
	input wire logic [1:0]  xfer_req
);
	logic [24:0] prev_r;
	logic [2:0]  cnt_r, cnt_nxt;
	wire logic [24:0] now = {straps, dma_req_tx, dma_req_rx, dma_req_timer};
	wire logic        ok = (cnt_r >= 3'h4) && (now == prev_r);
	wire logic [3:0]  b = straps.boot_sel;
	wire logic [3:0]  id = straps.id_sel;
	wire logic [2:0]  code = {straps.baud_code_strap_msb, straps.baud_code_strap_mid, straps.baud_code_strap_lsb};
	// Outputs other than rtc_tick are judged only once the inputs have been steady long enough to pass the synchronisers.
	always_comb begin
		cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
		if (now != prev_r) begin
			cnt_nxt = 3'h0;
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prev_r <= '0;
			cnt_r <= 3'h0;
		end else begin
			prev_r <= now;
			cnt_r <= cnt_nxt;
		end
	end
	function automatic logic [21:0] base(logic h, logic [3:0] i);
		if (i < 4'h8) begin
			return (h ? 22'o17762100 : 22'o17760100) + 22'(i - 4'h2) * 22'o40;
		end
		return (h ? 22'o17777400 : 22'o17775400) + 22'(i - 4'h8) * 22'o40;
	endfunction : base
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_bus_off: assert property (ok && id < 4'h2 |-> !bus_enable && slave_base == 22'h0)
		else $error("bus interface active for id 0 or 1");
	a_base_low: assert property (ok && id > 4'h1 && !straps.address_range_strap |-> bus_enable && slave_base == base(1'b0, id))
		else $error("low range base wrong");
	a_base_high: assert property (ok && id > 4'h1 && straps.address_range_strap |-> bus_enable && slave_base == base(1'b1, id))
		else $error("high range base wrong");
	a_boot_reserved: assert property (ok |-> boot_cfg.valid == !(b == 4'h7 || b > 4'hA))
		else $error("boot selector validity wrong");
	a_boot_user_rom: assert property (ok && b < 4'h3 |-> boot_cfg.run_mode == RUN_USER_ROM && boot_cfg.self_test == (b != 4'h0))
		else $error("user code boot decode wrong");
	a_boot_wait_cmd: assert property (ok && (b == 4'h5 || b == 4'h6) |->
		boot_cfg.run_mode == RUN_WAIT_CMD && boot_cfg.self_test == (b == 4'h5))
		else $error("arbiter wait decode wrong");
	a_boot_tape_mon: assert property (ok && (b == 4'h3 || b == 4'h4) |->
		boot_cfg.run_mode == (b == 4'h3 ? RUN_TAPE_LOAD : RUN_NONE) && boot_cfg.debug_monitor == (b == 4'h4))
		else $error("tape or monitor decode wrong");
	a_rtc_pulse: assert property (rtc_tick |=> !rtc_tick [*8])
		else $error("clock ticks too close");
	a_break_off: assert property (ok && !straps.break_trap_strap |-> !break_trap)
		else $error("break trap while disabled");
	a_baud_hw: assert property (ok && straps.baud_source_strap |-> baud_from_straps && baud_rate == 16'(38400 >> code))
		else $error("hardware baud wrong");
	a_dma_all: assert property (ok && straps.dma_route_strap == 3'h7 |-> xfer_req == 2'h0)
		else $error("unsupported route passes requests");
	a_dma_serial: assert property (ok && straps.dma_route_strap == 3'h6 |-> xfer_req == {dma_req_rx, dma_req_tx})
		else $error("serial request routing wrong");
endmodule : strap_cfg_checker
bind board_strap_config_decoder strap_cfg_checker u_chk (.clk_sys(clk_sys), .reset(reset), .straps(straps),
	.dma_req_tx(dma_req_tx), .dma_req_rx(dma_req_rx), .dma_req_timer(dma_req_timer), .boot_cfg(boot_cfg),
	.bus_enable(bus_enable), .slave_base(slave_base), .rtc_tick(rtc_tick), .break_trap(break_trap),
	.baud_from_straps(baud_from_straps), .baud_rate(baud_rate), .xfer_req(xfer_req));
`default_nettype wire

// >>> bench/peer_side_model.sv
// Console terminal and request sources that face the decoder.
`timescale 1ns/1ps
`default_nettype none
module peer_side_model (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       break_go,
	input  wire logic [2:0] req_in,
	output logic            console_break,
	output logic [2:0]      dma_req
);
	logic [1:0] hold_r, hold_nxt;
	logic [2:0] req_r;
	// A break holds the console line in the break state for three cycles.
	always_comb begin
		hold_nxt = (hold_r != 2'h0) ? hold_r - 2'h1 : 2'h0;
		if (break_go) begin
			hold_nxt = 2'h3;
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hold_r <= 2'h0;
			req_r <= 3'h0;
		end else begin
			hold_r <= hold_nxt;
			req_r <= req_in;
		end
	end
	assign console_break = hold_r != 2'h0;
	assign dma_req = req_r;
endmodule : peer_side_model
`default_nettype wire

// >>> bench/board_strap_config_decoder_tb.sv
// Self-checking testbench for the strap configuration decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: %0h vs %0h", $time, a, b); end end
module board_strap_config_decoder_tb
	import strap_cfg_pkg::*;
;
	logic        clk_sys = 0, reset = 1, break_go = 0, avs_read = 0, avs_write = 0;
	logic        avs_waitrequest, bus_enable, rtc_tick, break_trap, baud_from_straps, irq, console_break;
	logic [4:0]  avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, e, m;
	logic [31:0] exp_q[$], msk_q[$];
	logic [21:0] slave_base, eb;
	logic [15:0] baud_rate;
	logic [7:0]  rnd = 8'h06;
	logic [2:0]  req = 0, dma_req;
	logic [2:0]  rts[4] = '{3'h6, 3'h5, 3'h3, 3'h7};
	logic [1:0]  xfer_req;
	strap_in_t   st = '0;
	boot_cfg_t   boot_cfg;
	int          errors = 0, samples_checked = 0, n;
	always #2.5 clk_sys = ~clk_sys;
	board_strap_config_decoder #(.RTC_50_DIV(20), .RTC_60_DIV(16)) DUT (.clk_sys(clk_sys), .reset(reset), .straps(st),
		.console_break(console_break), .dma_req_tx(dma_req[2]), .dma_req_rx(dma_req[1]), .dma_req_timer(dma_req[0]),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .boot_cfg(boot_cfg),
		.bus_enable(bus_enable), .slave_base(slave_base), .rtc_tick(rtc_tick), .break_trap(break_trap),
		.baud_from_straps(baud_from_straps), .baud_rate(baud_rate), .xfer_req(xfer_req), .irq(irq));
	peer_side_model P (.clk_sys(clk_sys), .reset(reset), .break_go(break_go), .req_in(req),
		.console_break(console_break), .dma_req(dma_req));
	function automatic logic [7:0] lfsr(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic boot_cfg_t exp_boot(logic [3:0] s);
		boot_cfg_t c;
		c = '0;
		c.valid = !(s == 4'h7 || s > 4'hA);
		c.self_test = s inside {1, 2, 3, 5, 8, 9, 10};
		c.rom_test = s inside {2, 9};
		c.loopback_test = s inside {8, 9};
		c.ram_low = s inside {8, 9, 10};
		c.debug_monitor = s == 4'h4;
		c.diag_wait = s == 4'hA;
		c.run_mode = s < 4'h3 ? RUN_USER_ROM : s == 4'h3 ? RUN_TAPE_LOAD : s inside {5, 6} ? RUN_WAIT_CMD : RUN_NONE;
		return c;
	endfunction : exp_boot
	function automatic logic [21:0] exp_base(logic h, logic [3:0] i);
		if (i < 4'h2) begin
			return 22'h0;
		end
		if (i < 4'h8) begin
			return (h ? 22'o17762100 : 22'o17760100) + 22'(i - 4'h2) * 22'o40;
		end
		return (h ? 22'o17777400 : 22'o17775400) + 22'(i - 4'h8) * 22'o40;
	endfunction : exp_base
	function automatic logic [1:0] exp_dma(logic [2:0] rt, logic [2:0] r);
		case (rt)
			3'h6: return {r[1], r[2]};
			3'h5: return {r[0], r[2]};
			3'h3: return {r[1], r[0]};
			default: return 2'h0;
		endcase
	endfunction : exp_dma
	task automatic w5();
		repeat (5) @(posedge clk_sys);
	endtask : w5
	// One register access; a read leaves its expected word and compare mask for the monitor.
	task automatic bus(logic w, logic [4:0] a, logic [31:0] d, logic [31:0] x, logic [31:0] k);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		if (!w) begin
			exp_q.push_back(x);
			msk_q.push_back(k);
		end
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	always @(posedge clk_sys) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0) begin
				errors++;
			end else begin
				m = msk_q.pop_front();
				e = exp_q.pop_front();
				`CHK(avs_readdata & m, e)
			end
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		bus(0, REG_MASK_OFS, 0, 32'h0, '1);
		bus(0, REG_SWBAUD_OFS, 0, 32'h2, '1);
		bus(0, 5'h1C, 0, 32'h0, '1);
		`CHK({baud_from_straps, baud_rate}, {1'b0, 16'd9600})
		rnd = lfsr(rnd);
		bus(1, REG_SWBAUD_OFS, {29'h0, rnd[2:0]}, 0, 0);
		w5();
		`CHK(baud_rate, 16'(38400 >> rnd[2:0]))
		$display("test registers done");
		for (int i = 0; i < 16; i++) begin
			st.boot_sel <= 4'(i);
			w5();
			`CHK(boot_cfg, exp_boot(4'(i)))
			bus(0, 5'(REG_BOOT_OFS), 0, {18'h0, 4'(i), exp_boot(4'(i))}, '1);
		end
		bus(1, REG_MASK_OFS, 32'h4, 0, 0);
		st.boot_sel <= 4'h7;
		w5();
		`CHK(irq, 1'b1)
		bus(0, 5'(REG_STATUS_OFS), 0, 32'h4, 32'h4);
		st.boot_sel <= 4'h0;
		w5();
		bus(1, 5'(REG_STATUS_OFS), 32'h4, 0, 0);
		w5();
		`CHK(irq, 1'b0)
		bus(1, REG_MASK_OFS, 0, 0, 0);
		st.boot_sel <= 4'hF;
		w5();
		`CHK(irq, 1'b0)
		bus(1, REG_MASK_OFS, 32'h1, 0, 0);
		repeat (6) w5();
		`CHK(irq, 1'b1)
		$display("test boot done");
		for (int i = 0; i < 32; i++) begin
			st.id_sel <= 4'(i);
			st.address_range_strap <= i[4];
			w5();
			eb = exp_base(i[4], 4'(i));
			`CHK({bus_enable, slave_base}, {i[3:0] > 4'h1, eb})
			bus(0, 5'(REG_ADDR_OFS), 0, {5'h0, i[3:0] > 4'h1, 4'(i), eb}, '1);
		end
		for (int r = 0; r < 2; r++) begin
			st.clock_rate_strap <= r[0];
			st.break_trap_strap <= r[0];
			w5();
			repeat (2) @(posedge clk_sys iff rtc_tick === 1'b1);
			n = 0;
			do begin @(posedge clk_sys); n++; end while (rtc_tick !== 1'b1);
			`CHK(n, r ? 20 : 16)
			break_go <= 1'b1;
			@(posedge clk_sys);
			break_go <= 1'b0;
			n = 0;
			repeat (8) begin @(posedge clk_sys); if (break_trap === 1'b1) n++; end
			`CHK(n, r)
		end
		st.baud_source_strap <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			{st.baud_code_strap_msb, st.baud_code_strap_mid, st.baud_code_strap_lsb} <= 3'(k);
			w5();
			`CHK({baud_from_straps, baud_rate}, {1'b1, 16'(38400 >> k)})
			bus(0, 5'(REG_MISC_OFS), 0, {12'h0, 1'b1, 3'(k), 16'(38400 >> k)}, 32'h000FFFFF);
		end
		for (int j = 0; j < 16; j++) begin
			st.dma_route_strap <= rts[j / 4];
			rnd = lfsr(rnd);
			req <= rnd[2:0];
			w5();
			`CHK(xfer_req, exp_dma(rts[j / 4], rnd[2:0]))
			bus(0, 5'(REG_STATUS_OFS), 0, {28'h0, rts[j / 4] == 3'h7, 3'h0}, 32'h8);
		end
		$display("test straps done");
		summarize();
	end
	initial begin
		repeat (6000) @(posedge clk_sys);
		errors++;
		summarize();
	end
endmodule : board_strap_config_decoder_tb
`default_nettype wire
